// ===== hw/spi_fram_opcode_status_latch.v
// Function
// - status bit 0 ignores writes and always reads zero
// - status bits 4 to 7 are not writable and read zero
// - bit 1 shows write-permit latch; latch clear after reset
// - bits 2,3 hold protect selectors low/high, drive protect_select_low and protect_select_high only, reset zero
// - nine-bit byte address reaches all 512 locations
// - address msb travels in opcode bit 3 of read and write
// - lower half uses write 0x02 and read 0x03
// - upper half uses write 0x0A and read 0x0B
// - completed lower-range memory or status write clears the latch
// - completed upper-range 0x0A write leaves latch set
// - with latch still set, next write accepted without latch set
// - latch clear command clears latch, blocking writes until set again
// - latch set command sets the write-permit latch
// - status write data byte leaves the latch bit itself unchanged
`include "spi_cmd_defs.vh"
module spi_fram_opcode_status_latch (
    input wire clock,
    input wire rstn,
    input wire cs_n,
    input wire sck,
    input wire mosi,
    output reg miso_ff,
    output wire miso_oe,
    output reg [7:0] serial_memory_status_ff,
    output reg [8:0] mem_addr_ff,
    output reg [7:0] mem_wdata_ff,
    output reg mem_we_ff,
    output reg mem_re_ff,
    input wire [7:0] mem_rdata,
    output wire protect_select_low,
    output wire protect_select_high,
    output wire write_permit_latch
);
    localparam ST_IDLE = 5'h01;
    localparam ST_ADDR = 5'h02;
    localparam ST_WDATA = 5'h04;
    localparam ST_RDATA = 5'h08;
    localparam ST_SWR = 5'h10;

    reg [1:0] rst_sync_ff;
    wire rst_n = rst_sync_ff[1];
    reg [2:0] cs_sync_ff;
    reg [2:0] sck_sync_ff;
    reg [1:0] mosi_sync_ff;
    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg is_write_ff;
    reg hi_write_ff;
    reg wrote_ff;
    reg [7:0] shift_out_ff;
    reg [8:0] nxt_addr;
    wire [7:0] rx_byte;
    wire rx_done;
    wire [2:0] rx_count;
    wire frame = ~cs_sync_ff[1];
    wire frame_end = cs_sync_ff[1] & ~cs_sync_ff[2];
    wire sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
    wire sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
    wire first_byte = (state_ff == ST_IDLE);

    function is_mem_op;
        input [7:0] op;
        input rd;
        begin
            // bit 3 is the address msb, mask it before matching
            is_mem_op = ((op & 8'hF7) == (rd ? `OP_READ_LO : `OP_WRITE_LO));
        end
    endfunction

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_ff <= 3'h7;
            sck_sync_ff <= 3'h0;
            mosi_sync_ff <= 2'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], cs_n};
            sck_sync_ff <= {sck_sync_ff[1:0], sck};
            mosi_sync_ff <= {mosi_sync_ff[0], mosi};
        end
    end

    spi_shift_in u_shift (
        .clock(clock),
        .rst_n(rst_n),
        .frame(frame),
        .sck_rise(sck_rise),
        .mosi(mosi_sync_ff[1]),
        .byte_ff(rx_byte),
        .byte_done_ff(rx_done),
        .count_ff(rx_count)
    );

    assign write_permit_latch = serial_memory_status_ff[`ST_PERMIT_BIT];
    assign protect_select_low = serial_memory_status_ff[`ST_PSEL_LO_BIT];
    assign protect_select_high = serial_memory_status_ff[`ST_PSEL_HI_BIT];
    assign miso_oe = frame & (state_ff == ST_RDATA);

    always @* begin
        nxt_state = state_ff;
        nxt_addr = mem_addr_ff;
        case (state_ff)
            ST_IDLE: begin
                if (rx_done) begin
                    if (is_mem_op(rx_byte, 1'b1) ||
                        is_mem_op(rx_byte, 1'b0)) begin
                        nxt_state = ST_ADDR;
                        nxt_addr = {rx_byte[`OP_ADDR_MSB_BIT], 8'h00};
                    end else if (rx_byte == `OP_STATUS_WRITE) begin
                        nxt_state = ST_SWR;
                    end else if (rx_byte == `OP_STATUS_READ) begin
                        nxt_state = ST_RDATA;
                    end
                end
            end
            ST_ADDR: begin
                if (rx_done) begin
                    nxt_addr = {mem_addr_ff[8], rx_byte};
                    nxt_state = is_write_ff ? ST_WDATA : ST_RDATA;
                end
            end
            ST_WDATA: begin
                nxt_state = ST_WDATA;
            end
            ST_RDATA: begin
                nxt_state = ST_RDATA;
            end
            ST_SWR: begin
                nxt_state = ST_SWR;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (!frame) begin
            nxt_state = ST_IDLE;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            mem_addr_ff <= 9'h000;
            mem_wdata_ff <= 8'h00;
            mem_we_ff <= 1'b0;
            mem_re_ff <= 1'b0;
            is_write_ff <= 1'b0;
            hi_write_ff <= 1'b0;
            wrote_ff <= 1'b0;
            shift_out_ff <= 8'h00;
            miso_ff <= 1'b0;
            serial_memory_status_ff <= `ST_RESET;
        end else begin
            state_ff <= nxt_state;
            mem_addr_ff <= nxt_addr;
            mem_we_ff <= 1'b0;
            mem_re_ff <= 1'b0;
            if (first_byte && rx_done) begin
                is_write_ff <= is_mem_op(rx_byte, 1'b0);
                // upper-range write opcode does not arm the clear
                hi_write_ff <= (rx_byte == `OP_WRITE_HI);
                wrote_ff <= 1'b0;
                if (rx_byte == `OP_LATCH_SET) begin
                    serial_memory_status_ff[`ST_PERMIT_BIT] <= 1'b1;
                end
                if (rx_byte == `OP_LATCH_CLEAR) begin
                    serial_memory_status_ff[`ST_PERMIT_BIT] <= 1'b0;
                end
                if (rx_byte == `OP_STATUS_READ) begin
                    shift_out_ff <= serial_memory_status_ff & 8'h0C |
                        {6'h00, serial_memory_status_ff[1], 1'b0};
                end
            end
            if (state_ff == ST_ADDR && rx_done && !is_write_ff) begin
                mem_re_ff <= 1'b1;
            end
            if (state_ff == ST_WDATA && rx_done && write_permit_latch) begin
                mem_wdata_ff <= rx_byte;
                mem_we_ff <= 1'b1;
                wrote_ff <= 1'b1;
            end
            if (mem_we_ff) begin
                mem_addr_ff <= mem_addr_ff + 9'h001;
            end
            // only the first data byte of a status write counts
            if (state_ff == ST_SWR && rx_done && !wrote_ff &&
                write_permit_latch) begin
                // only protect selectors are writable; latch bit kept
                serial_memory_status_ff[`ST_PSEL_LO_BIT] <=
                    rx_byte[`ST_PSEL_LO_BIT];
                serial_memory_status_ff[`ST_PSEL_HI_BIT] <=
                    rx_byte[`ST_PSEL_HI_BIT];
                wrote_ff <= 1'b1;
            end
            if (frame_end && wrote_ff && !hi_write_ff) begin
                serial_memory_status_ff[`ST_PERMIT_BIT] <= 1'b0;
                wrote_ff <= 1'b0;
            end else if (frame_end) begin
                wrote_ff <= 1'b0;
            end
            if (state_ff == ST_RDATA) begin
                if (mem_re_ff) begin
                    shift_out_ff <= mem_rdata;
                end else if (sck_fall && rx_count != 3'h0) begin
                    // fall closing the command byte must not shift:
                    // bit 7 is already out for the first rise
                    shift_out_ff <= {shift_out_ff[6:0], 1'b0};
                end
            end
            miso_ff <= shift_out_ff[7];
        end
    end
endmodule

// ===== hw/spi_cmd_defs.vh
`ifndef SPI_CMD_DEFS_VH
`define SPI_CMD_DEFS_VH
`define OP_WRITE_LO 8'h02
`define OP_READ_LO 8'h03
`define OP_WRITE_HI 8'h0A
`define OP_READ_HI 8'h0B
`define OP_ADDR_MSB_BIT 3
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define ST_PERMIT_BIT 1
`define ST_PSEL_LO_BIT 2
`define ST_PSEL_HI_BIT 3
`define ST_RESET 8'h00
`define ADDR_W 9
`endif

// ===== hw/spi_shift_in.v
module spi_shift_in (
    input wire clock,
    input wire rst_n,
    input wire frame,
    input wire sck_rise,
    input wire mosi,
    output reg [7:0] byte_ff,
    output reg byte_done_ff,
    output reg [2:0] count_ff
);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            byte_ff <= 8'h00;
            byte_done_ff <= 1'b0;
            count_ff <= 3'h0;
        end else begin
            byte_done_ff <= 1'b0;
            if (!frame) begin
                count_ff <= 3'h0;
            end else if (sck_rise) begin
                byte_ff <= {byte_ff[6:0], mosi};
                count_ff <= count_ff + 3'h1;
                if (count_ff == 3'h7) begin
                    byte_done_ff <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== test/host_model.sv
module host_model (
    input wire clock,
    input wire miso_ff,
    input wire miso_oe,
    output logic cs_n = 1'b1,
    output logic sck = 1'b0,
    output logic mosi = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tog = 1'b0;
    // released line toggles so a stale bit cannot pass for data
    wire line = miso_oe ? miso_ff : tog;
    always @(posedge clock) tog <= ~tog;
    function [7:0] op(input rd, input [8:0] a);
        op = {4'h0, a[8], 2'b01, rd};
    endfunction
    // mode 0, seven clocks low and six high per bit to get past the input syncs
    task send(input [23:0] b, input int n, output [7:0] q);
        @(posedge clock) cs_n <= 1'b0;
        for (int k = 0; k < n; k++)
            for (int i = 7; i >= 0; i--) begin
                @(posedge clock) mosi <= b[16 - 8 * k + i];
                repeat (6) @(posedge clock);
                q[i] = line;
                sck <= 1'b1;
                repeat (6) @(posedge clock);
                sck <= 1'b0;
            end
    endtask
    task close;
        repeat (6) @(posedge clock);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (12) @(posedge clock);
    endtask
endmodule

// ===== test/opcode_latch_props.sv
module opcode_latch_props (
    input wire clock,
    input wire rstn,
    input wire [7:0] serial_memory_status_ff,
    input wire [8:0] mem_addr_ff,
    input wire mem_we_ff,
    input wire mem_re_ff,
    input wire miso_oe,
    input wire protect_select_low,
    input wire protect_select_high,
    input wire write_permit_latch
);
    wire [7:0] st = serial_memory_status_ff;
    wire [1:0] sel = {protect_select_high, protect_select_low};
    wire wpl = write_permit_latch;
    wire hi = mem_we_ff && mem_addr_ff[8];
    wire lo = mem_we_ff && !mem_addr_ff[8];
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_held;
        wpl [*8];
    endsequence
    a_bit0_zero: assert property (!st[0]) else $error("bit 0 set");
    a_top_zero: assert property (st[7:4] == 4'h0) else $error("top set");
    a_latch_bit: assert property (wpl == st[1]) else $error("latch");
    a_sel_bits: assert property (sel == st[3:2]) else $error("select");
    a_we_gated: assert property (mem_we_ff |-> wpl) else $error("we");
    a_sel_gated: assert property ($changed(st[3:2]) |-> $past(wpl))
        else $error("select changed");
    // 24 cycles reach past the frame end that would clear it
    a_hi_keeps: assert property (hi |=> s_held ##1 s_held ##1 s_held)
        else $error("hi");
    a_re_in_read: assert property (mem_re_ff |-> miso_oe)
        else $error("read pulse outside read phase");
    a_lo_clears: assert property (lo |-> ##[1:400] !wpl)
        else $error("lo");
endmodule
bind spi_fram_opcode_status_latch opcode_latch_props i_props (.*);

// ===== test/tb_top.sv
`include "spi_cmd_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    wire cs_n, sck, mosi, miso_ff, miso_oe, mem_we_ff, mem_re_ff;
    wire protect_select_low, protect_select_high, write_permit_latch;
    wire [7:0] serial_memory_status_ff, mem_wdata_ff;
    wire [8:0] mem_addr_ff;
    logic [7:0] mem [0:511] = '{default: 8'h00};
    // read combinationally so data is there in the cycle re is high
    wire [7:0] mem_rdata = mem[mem_addr_ff];
    logic [7:0] q;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    spi_fram_opcode_status_latch i_spi_fram_opcode_status_latch (.*);
    host_model i_host_model (.*);
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        if (mem_we_ff === 1'b1)
            mem[mem_addr_ff] <= mem_wdata_ff;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: timeout", $time);
            tally_and_finish;
        end
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task run(input [23:0] b, input int n);
        i_host_model.send(b, n, q);
        i_host_model.close;
    endtask
    task c1(input [7:0] o); run({o, 16'h0000}, 1); endtask
    task sw(input [7:0] d); run({`OP_STATUS_WRITE, d, 8'h00}, 2); endtask
    task sr(input [7:0] e);
        run({`OP_STATUS_READ, 16'h0000}, 2);
        check(q, e);
    endtask
    task wr(input [8:0] a, input [7:0] d);
        run({i_host_model.op(1'b0, a), a[7:0], d}, 3);
    endtask
    task rd(input [8:0] a, input [7:0] e);
        run({i_host_model.op(1'b1, a), a[7:0], 8'h00}, 3);
        check(q, e);
    endtask
    task done(input string s); $display("test %s done", s); endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (10) @(posedge clock);
        sr(`ST_RESET);
        sw(8'hFF);
        sr(8'h00);
        c1(`OP_LATCH_SET);
        sr(8'h02);
        i_host_model.send({`OP_STATUS_WRITE, 8'hFD, 8'h00}, 2, q);
        repeat (6) @(posedge clock);
        check({7'h00, write_permit_latch}, 8'h01);
        i_host_model.close;
        sr(8'h0C);
        done("status");
        c1(`OP_LATCH_SET);
        c1(`OP_LATCH_CLEAR);
        wr(9'h055, 8'hA5);
        rd(9'h055, 8'h00);
        c1(`OP_LATCH_SET);
        wr(9'h055, 8'h5A);
        sr(8'h0C);
        c1(`OP_LATCH_SET);
        wr(9'h155, 8'hC3);
        sr(8'h0E);
        wr(9'h1AA, 8'h3C);
        sw(8'h00);
        sr(8'h00);
        c1(`OP_LATCH_SET);
        wr(9'h1FF, 8'h99);
        c1(`OP_LATCH_CLEAR);
        sr(8'h00);
        rd(9'h055, 8'h5A);
        rd(9'h155, 8'hC3);
        rd(9'h1AA, 8'h3C);
        done("memory");
        tally_and_finish;
    end
endmodule
